/* File: core/ipa_ctrl.sv */
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
// Summary of operation
// - 35 ranks: level high first, then priority 11,10, external pin, 01,00
// - pin seven is level 7, below internal 11 and 10
// - pin three at level 6 when middle select bit set, else level 3
// - pin five at level 5 when upper select bit clear, else level 4
// - pin one at level 1 when low select bit clear, else level 2
// - simultaneous requests serviced from best rank to worst
// - per external level bit: 0 source gives vector, 1 autovector
// - strobe block bit stops address strobe during external autovector access
// - autovector offset 0x64 for level 1, plus four per level to 0x7c
// - external autovector bit ignored unless that level is selected by pins
// - internal sources take autovector choice from their own control bit
// - source control: level in bits 4..2, priority in bits 1..0
// - pin select bits 7..5 set levels of pins five, three, one
// - masked request shows pending but never arbitrates or reaches core
module ipa_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // request sources
  input wire logic [9:0] int_req,
  input wire logic ext_request_pin_one,
  input wire logic ext_request_pin_three,
  input wire logic ext_request_pin_five,
  input wire logic ext_request_pin_seven,
  // core side
  output logic [2:0] core_level,
  input wire logic iack,
  input wire logic ext_ack_cycle,
  input wire logic address_strobe_req,
  output logic address_strobe,
  output logic ack_valid,
  output logic ack_autovec,
  output logic ack_external,
  output logic [4:0] ack_source,
  output logic [7:0] ack_vec_offset,
  // interrupt to software
  output logic irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_DONE} ipa_bus_st_t;

  // rank key: lower is better
  function automatic logic [5:0] rank_of(input logic [2:0] lvl, input logic [2:0] slot);
    logic [5:0] base;
    base = 6'd5 * {3'd0, 3'd7 - lvl};
    rank_of = base + {3'd0, slot};
  endfunction

  // internal priority code to slot within a level, external pin sits between
  function automatic logic [2:0] slot_of(input logic [1:0] pri);
    case (pri)
      2'b11: slot_of = 3'd0;
      2'b10: slot_of = 3'd1;
      2'b01: slot_of = 3'd3;
      default: slot_of = 3'd4;
    endcase
  endfunction

  ipa_bus_st_t st_q;
  logic [7:0] avc_q;
  logic [7:0] pinsel_q;
  logic [17:0] mask_q;
  logic [17:0] pend_q;
  logic [1:0] istat_q;
  logic [1:0] imask_q;
  logic [79:0] sc_all;
  logic [7:0] sc_rd;
  logic [2:0] ext_lvl_pin_five, ext_lvl_pin_three, ext_lvl_pin_one;
  logic [7:1] ext_lvl_req;
  logic [7:1] ext_lvl_enabled;
  logic [5:0] best_rank;
  logic [4:0] best_src;
  logic [2:0] best_lvl;
  logic best_ext;
  logic best_any;
  logic [31:0] rd_mux;
  logic wr_acc;
  logic sc_wr;
  logic [3:0] sc_wr_idx;
  logic [3:0] sc_rd_idx;
  logic iack_q;
  logic [7:0] win_sc;

  assign wr_acc = psel && penable && pwrite && pready;

  // three control words hold four, four and two bytes, byte 0 at the top lane
  always_comb begin
    sc_wr = 1'b0;
    sc_wr_idx = 4'd0;
    if (wr_acc) begin
      if (paddr == ipa_pkg::OFS_SRC0) begin
        sc_wr = 1'b1;
        sc_wr_idx = 4'd0;
      end else if (paddr == ipa_pkg::OFS_SRC1) begin
        sc_wr = 1'b1;
        sc_wr_idx = 4'd4;
      end else if (paddr == ipa_pkg::OFS_SRC2) begin
        sc_wr = 1'b1;
        sc_wr_idx = 4'd8;
      end
    end
  end

  // writes land one byte per cycle would cost cycles; instead use the full word
  // path below for all four lanes through sequential indices is avoided by
  // storing via direct lanes: only the top lane goes through memory port
  logic [7:0] sc_wr_byte;
  assign sc_wr_byte = pwdata[31:24];
  assign sc_rd_idx = (paddr == ipa_pkg::OFS_SRC1) ? 4'd4 :
                     (paddr == ipa_pkg::OFS_SRC2) ? 4'd8 : 4'd0;

  ipa_ctl_mem u_mem (
    .mclk(mclk),
    .srst(srst),
    .wr_en(sc_wr),
    .wr_idx(sc_wr_idx),
    .wr_data(sc_wr_byte),
    .rd_idx(sc_rd_idx),
    .rd_data(sc_rd),
    .all_data(sc_all)
  );

  // other lanes of the control words live in flops next to the store
  logic [7:0] lane_q [10];
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 10; i++) begin
        lane_q[i] <= ipa_pkg::SC_RESET;
      end
    end else if (sc_wr) begin
      if (sc_wr_idx + 4'd1 < 4'd10) begin
        lane_q[sc_wr_idx + 4'd1] <= pwdata[23:16];
      end
      if (sc_wr_idx + 4'd2 < 4'd10) begin
        lane_q[sc_wr_idx + 4'd2] <= pwdata[15:8];
      end
      if (sc_wr_idx + 4'd3 < 4'd10) begin
        lane_q[sc_wr_idx + 4'd3] <= pwdata[7:0];
      end
    end
  end

  function automatic logic [7:0] sc_byte(input logic [79:0] mem, input int i,
                                         input logic [7:0] ln);
    // first byte of each word comes from the store, the rest from lane flops
    sc_byte = ((i % 4) == 0) ? mem[i*8 +: 8] : ln;
  endfunction

  // apb: one wait state, reads take the registered store output
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: if (psel && !penable) st_q <= ST_RD;
        ST_RD: st_q <= ST_DONE;
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  assign pready = (st_q == ST_DONE);

  always_comb begin
    rd_mux = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      ipa_pkg::OFS_PENDING: rd_mux = {14'h0000, pend_q};
      ipa_pkg::OFS_MASK: rd_mux = {14'h0000, mask_q};
      ipa_pkg::OFS_AVC: rd_mux = {24'h000000, avc_q};
      ipa_pkg::OFS_SRC0: rd_mux = {sc_rd, lane_q[1], lane_q[2], lane_q[3]};
      ipa_pkg::OFS_SRC1: rd_mux = {sc_rd, lane_q[5], lane_q[6], lane_q[7]};
      ipa_pkg::OFS_SRC2: rd_mux = {sc_rd, lane_q[9], 16'h0000};
      ipa_pkg::OFS_PINSEL: rd_mux = {24'h000000, pinsel_q};
      ipa_pkg::OFS_IRQ_STAT: rd_mux = {30'h00000000, istat_q};
      ipa_pkg::OFS_IRQ_MASK: rd_mux = {30'h00000000, imask_q};
      ipa_pkg::OFS_ACK: rd_mux = {16'h0000, ack_external, best_src, 2'h0, ack_vec_offset};
      default: pslverr = pready;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (st_q == ST_RD) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      avc_q <= ipa_pkg::AVC_RESET;
      pinsel_q <= ipa_pkg::PINSEL_RESET;
      mask_q <= ipa_pkg::MASK_RESET;
      imask_q <= 2'h0;
    end else if (wr_acc) begin
      case (paddr)
        ipa_pkg::OFS_AVC: avc_q <= pwdata[7:0];
        ipa_pkg::OFS_PINSEL: pinsel_q <= {pwdata[7:5], 5'h00};
        ipa_pkg::OFS_MASK: mask_q <= {pwdata[17:1], 1'b0};
        ipa_pkg::OFS_IRQ_MASK: imask_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // pin level mapping
  assign ext_lvl_pin_five = pinsel_q[ipa_pkg::PIN_SEL_LSB + 2] ? 3'd4 : 3'd5;
  assign ext_lvl_pin_three = pinsel_q[ipa_pkg::PIN_SEL_LSB + 1] ? 3'd6 : 3'd3;
  assign ext_lvl_pin_one = pinsel_q[ipa_pkg::PIN_SEL_LSB] ? 3'd2 : 3'd1;

  always_comb begin
    ext_lvl_enabled = 7'h00;
    ext_lvl_enabled[7] = 1'b1;
    ext_lvl_enabled[ext_lvl_pin_five] = 1'b1;
    ext_lvl_enabled[ext_lvl_pin_three] = 1'b1;
    ext_lvl_enabled[ext_lvl_pin_one] = 1'b1;
    ext_lvl_req = 7'h00;
    ext_lvl_req[7] = ext_request_pin_seven;
    ext_lvl_req[ext_lvl_pin_five] = ext_request_pin_five;
    ext_lvl_req[ext_lvl_pin_three] = ext_request_pin_three;
    ext_lvl_req[ext_lvl_pin_one] = ext_request_pin_one;
  end

  // pending samples every clock regardless of mask
  always_ff @(posedge mclk) begin
    if (srst) begin
      pend_q <= 18'h00000;
    end else begin
      pend_q <= {ext_lvl_req, int_req, 1'b0};
    end
  end

  // arbitration over pending unmasked external requests and internal ones whose level is nonzero
  always_comb begin
    logic [7:0] b;
    logic [5:0] r;
    b = 8'h00;
    r = 6'd0;
    best_rank = ipa_pkg::RANK_NONE;
    best_src = 5'd0;
    best_lvl = 3'd0;
    best_ext = 1'b0;
    for (int i = 0; i < 10; i++) begin
      b = sc_byte(sc_all, i, lane_q[i]);
      r = rank_of(b[4:2], slot_of(b[1:0]));
      if (pend_q[ipa_pkg::PEND_INT_LSB + i] && !mask_q[ipa_pkg::PEND_INT_LSB + i]
          && b[4:2] != 3'd0 && r < best_rank) begin
        best_rank = r;
        best_src = 5'(i);
        best_lvl = b[4:2];
        best_ext = 1'b0;
      end
    end
    for (int l = 1; l < 8; l++) begin
      r = rank_of(3'(l), ipa_pkg::EXT_PRI_SLOT);
      if (pend_q[ipa_pkg::PEND_EXT_LSB + l - 1] && !mask_q[ipa_pkg::PEND_EXT_LSB + l - 1]
          && r < best_rank) begin
        best_rank = r;
        best_src = 5'(l);
        best_lvl = 3'(l);
        best_ext = 1'b1;
      end
    end
  end
  assign best_any = (best_rank != ipa_pkg::RANK_NONE);
  assign core_level = best_any ? best_lvl : 3'd0;

  // control byte of the current winner, for its own autovector bit
  assign win_sc = sc_byte(sc_all, int'(best_src), lane_q[best_src[3:0]]);

  // acknowledge: latch winner on the rising edge of iack
  always_ff @(posedge mclk) begin
    if (srst) begin
      iack_q <= 1'b0;
      ack_valid <= 1'b0;
      ack_autovec <= 1'b0;
      ack_external <= 1'b0;
      ack_source <= 5'd0;
      ack_vec_offset <= 8'h00;
    end else begin
      iack_q <= iack;
      ack_valid <= iack && !iack_q && best_any;
      if (iack && !iack_q && best_any) begin
        ack_external <= best_ext;
        ack_source <= best_src;
        ack_vec_offset <= ipa_pkg::AUTOVEC_BASE + {3'd0, best_lvl, 2'b00};
        if (best_ext) begin
          ack_autovec <= avc_q[best_lvl] && ext_lvl_enabled[best_lvl];
        end else begin
          ack_autovec <= win_sc[ipa_pkg::SC_AUTOVECTOR_SELECT];
        end
      end
    end
  end

  // gate from the first cycle of the access: ack fields already stand by then
  assign address_strobe = address_strobe_req &&
                          !(avc_q[ipa_pkg::AVC_BLK] && ext_ack_cycle &&
                            ack_external && ack_autovec);

  // software interrupt events: bit0 new acknowledge, bit1 masked request pending
  always_ff @(posedge mclk) begin
    if (srst) begin
      istat_q <= 2'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (k == 0 ? ack_valid : |(pend_q & mask_q)) begin
          istat_q[k] <= 1'b1;
        end else if (wr_acc && paddr == ipa_pkg::OFS_IRQ_STAT && pwdata[k]) begin
          istat_q[k] <= 1'b0;
        end
      end
    end
  end
  assign irq = |(istat_q & imask_q);
endmodule

/* File: core/ipa_pkg.sv */
package ipa_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_PENDING = 8'h40;
  localparam logic [7:0] OFS_MASK = 8'h44;
  localparam logic [7:0] OFS_AVC = 8'h48;
  localparam logic [7:0] OFS_SRC0 = 8'h4c;
  localparam logic [7:0] OFS_SRC1 = 8'h50;
  localparam logic [7:0] OFS_SRC2 = 8'h54;
  localparam logic [7:0] OFS_PINSEL = 8'h58;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h5c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h60;
  localparam logic [7:0] OFS_ACK = 8'h64;
  localparam int NSRC = 10;
  // pending/mask layout: bits 10..1 internal sources, 17..11 external levels 1..7
  localparam int PEND_INT_LSB = 1;
  localparam int PEND_EXT_LSB = 11;
  // source control fields
  localparam int SC_AUTOVECTOR_SELECT = 7;
  localparam int SC_LVL_LSB = 2;
  localparam int SC_PRI_LSB = 0;
  localparam int PIN_SEL_LSB = 5;
  localparam int AVC_BLK = 0;
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [7:0] AVC_RESET = 8'h00;
  localparam logic [7:0] PINSEL_RESET = 8'h00;
  localparam logic [17:0] MASK_RESET = 18'h3fffe;
  localparam logic [7:0] AUTOVEC_BASE = 8'h60;
  localparam logic [5:0] RANK_NONE = 6'h3f;
  localparam logic [2:0] EXT_PRI_SLOT = 3'h2;
endpackage

/* File: core/ipa_ctl_mem.sv */
`timescale 1ns/10ps
// small register store with ten byte slots, written only with the first byte of each source control word, registered read
module ipa_ctl_mem (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // write port
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [7:0] wr_data,
  // registered read port
  input wire logic [3:0] rd_idx,
  output logic [7:0] rd_data,
  // all bytes for the arbiter
  output logic [79:0] all_data
);
  logic [7:0] mem_q [10];

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 10; i++) begin
        mem_q[i] <= ipa_pkg::SC_RESET;
      end
    end else if (wr_en && wr_idx < 4'd10) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_data <= 8'h00;
    end else if (rd_idx < 4'd10) begin
      rd_data <= mem_q[rd_idx];
    end else begin
      rd_data <= 8'h00;
    end
  end

  always_comb begin
    for (int i = 0; i < 10; i++) begin
      all_data[i*8 +: 8] = mem_q[i];
    end
  end
endmodule

/* File: test/ipa_ctrl_asserts.sv */
`timescale 1ns/10ps
module ipa_ctrl_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire logic [2:0] core_level,
  input wire logic iack,
  input wire logic ext_ack_cycle,
  input wire logic address_strobe_req,
  input wire logic address_strobe,
  input wire logic ack_valid,
  input wire logic ack_autovec,
  input wire logic ack_external,
  input wire logic [4:0] ack_source,
  input wire logic [7:0] ack_vec_offset
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  chk_apb_wait: assert property (psel && !penable |-> !pready ##1 !pready ##1 pready)
    else $error("apb answer out of place");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_ack_single: assert property (ack_valid |=> !ack_valid)
    else $error("ack pulse too long");
  chk_ack_cause: assert property (ack_valid |-> $past(iack) && !$past(iack, 2))
    else $error("ack without iack rise");
  chk_ack_winner: assert property (ack_valid |-> $past(core_level) != 3'h0)
    else $error("ack with no winner");
  chk_autovector_select_offset: assert property (ack_valid && ack_autovec && ack_external |->
    ack_vec_offset == {3'h3, ack_source[2:0], 2'h0})
    else $error("bad autovector offset");
  chk_ext_level: assert property (ack_valid && ack_external |-> ack_source inside {[1:7]})
    else $error("bad external level");
  chk_int_index: assert property (ack_valid && !ack_external |-> ack_source < 5'ha)
    else $error("bad internal index");
  chk_strobe_pass: assert property (!ext_ack_cycle |->
    address_strobe == address_strobe_req)
    else $error("strobe altered outside ack");
  chk_strobe_gate: assert property (address_strobe != address_strobe_req |->
    ack_external && ack_autovec)
    else $error("strobe gated wrongly");
endmodule

bind ipa_ctrl ipa_ctrl_asserts u_chk (.mclk(mclk), .srst(srst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .core_level(core_level),
  .iack(iack), .ext_ack_cycle(ext_ack_cycle), .address_strobe_req(address_strobe_req),
  .address_strobe(address_strobe), .ack_valid(ack_valid), .ack_autovec(ack_autovec),
  .ack_external(ack_external), .ack_source(ack_source), .ack_vec_offset(ack_vec_offset));

/* File: test/ipa_core_model.sv */
`timescale 1ns/10ps
module ipa_core_model (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // bench control
  input wire logic go,
  input wire logic [1:0] slow,
  // acknowledge side
  output logic iack,
  output logic ext_ack_cycle,
  output logic address_strobe_req
);
  initial begin
    iack = 1'b0;
    ext_ack_cycle = 1'b0;
    address_strobe_req = 1'b0;
  end
  // slow stretches the gap before the bus cycle
  always begin
    @(posedge mclk);
    if (go && !srst) begin
      iack <= 1'b1;
      repeat (32'(slow) + 1) @(posedge mclk);
      ext_ack_cycle <= 1'b1;
      address_strobe_req <= 1'b1;
      repeat (3) @(posedge mclk);
      iack <= 1'b0;
      ext_ack_cycle <= 1'b0;
      address_strobe_req <= 1'b0;
    end
  end
endmodule

/* File: test/tb_interrupt_priority_autovector.sv */
`timescale 1ns/10ps
module tb_interrupt_priority_autovector;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] int_req = 10'h000;
  logic [3:0] pin = 4'h0;
  logic go = 1'b0;
  logic [1:0] slow = 2'h0;
  logic [31:0] prdata;
  logic pready, pslverr, iack, ext_ack_cycle, address_strobe_req, address_strobe;
  logic ack_valid, ack_autovec, ack_external, irq;
  logic [2:0] core_level, lv;
  logic [4:0] ack_source;
  logic [7:0] ack_vec_offset, avc;
  logic [14:0] exp_q[$];
  int fail_count = 0;
  int checks_done = 0;
  int seed = 75;
  wire [14:0] ack_word = {ack_external, ack_autovec, ack_source,
    ack_autovec ? ack_vec_offset : 8'h00};
  always #50 mclk = ~mclk;
  ipa_ctrl DUT (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .int_req(int_req), .ext_request_pin_one(pin[0]), .ext_request_pin_three(pin[1]),
    .ext_request_pin_five(pin[2]), .ext_request_pin_seven(pin[3]), .core_level(core_level),
    .iack(iack), .ext_ack_cycle(ext_ack_cycle), .address_strobe_req(address_strobe_req),
    .address_strobe(address_strobe), .ack_valid(ack_valid), .ack_autovec(ack_autovec),
    .ack_external(ack_external), .ack_source(ack_source), .ack_vec_offset(ack_vec_offset),
    .irq(irq));
  ipa_core_model u_core (.mclk(mclk), .srst(srst), .go(go), .slow(slow), .iack(iack),
    .ext_ack_cycle(ext_ack_cycle), .address_strobe_req(address_strobe_req));
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [32:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    cmp(r, e);
  endtask
  // one acknowledge through the core model; strobe looked at mid bus cycle
  task automatic svc(input logic ext, input logic av, input logic [4:0] src,
      input logic [2:0] l, input logic strobe_block);
    exp_q.push_back({ext, av, src, av ? 8'h60 + {3'h0, l, 2'h0} : 8'h00});
    slow <= 2'($random(seed));
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    do @(posedge mclk); while (ext_ack_cycle !== 1'b1);
    @(negedge mclk);
    cmp(33'(address_strobe), 33'(!strobe_block));
    repeat (4) @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    if (ack_valid === 1'b1)
      cmp(33'(ack_word), exp_q.size() ? 33'(exp_q.pop_front()) : 33'h1_0000_0000);
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rdc(ipa_pkg::OFS_MASK, 33'(ipa_pkg::MASK_RESET));
    rdc(ipa_pkg::OFS_AVC, 33'h0);
    rdc(ipa_pkg::OFS_PINSEL, 33'h0);
    rdc(8'h70, 33'h1_0000_0000);
    $display("reset values done");
    wr(ipa_pkg::OFS_MASK, 32'h0);
    wr(ipa_pkg::OFS_PINSEL, 32'h40);
    wr(ipa_pkg::OFS_AVC, 32'h41);
    wr(ipa_pkg::OFS_SRC1, 32'h199a_0000);
    rdc(ipa_pkg::OFS_SRC1, 33'h199a_0000);
    int_req[5:4] <= 2'h3;
    pin[1] <= 1'b1;
    repeat (3) @(posedge mclk);
    cmp(33'(core_level), 33'h6);
    svc(1'b0, 1'b1, 5'h5, 3'h6, 1'b0);
    int_req[5] <= 1'b0;
    svc(1'b1, 1'b1, 5'h6, 3'h6, 1'b1);
    pin[1] <= 1'b0;
    svc(1'b0, 1'b0, 5'h4, 3'h6, 1'b0);
    int_req[4] <= 1'b0;
    $display("ordering done");
    avc = 8'($random(seed));
    wr(ipa_pkg::OFS_AVC, 32'(avc));
    for (int p = 0; p < 8; p++) begin
      wr(ipa_pkg::OFS_PINSEL, 32'(p) << 5);
      for (int k = 0; k < 4; k++) begin
        lv = k == 0 ? (p[0] ? 3'h2 : 3'h1) : k == 1 ? (p[1] ? 3'h6 : 3'h3) :
          k == 2 ? (p[2] ? 3'h4 : 3'h5) : 3'h7;
        pin <= 4'h1 << k;
        repeat (3) @(posedge mclk);
        cmp(33'(core_level), 33'(lv));
        svc(1'b1, avc[lv], {2'h0, lv}, lv, avc[lv] & avc[0]);
      end
    end
    $display("pin levels done");
    pin <= 4'h0;
    wr(ipa_pkg::OFS_MASK, 32'h20);
    int_req[4] <= 1'b1;
    repeat (3) @(posedge mclk);
    cmp(33'(core_level), 33'h0);
    rdc(ipa_pkg::OFS_PENDING, 33'h20);
    wr(ipa_pkg::OFS_IRQ_MASK, 32'h1);
    cmp(33'(irq), 33'h1);
    wr(ipa_pkg::OFS_IRQ_STAT, 32'h1);
    cmp(33'(irq), 33'h0);
    wr(ipa_pkg::OFS_IRQ_MASK, 32'h2);
    cmp(33'(irq), 33'h1);
    // masked request still pending, so the set beats the clear
    wr(ipa_pkg::OFS_IRQ_STAT, 32'h2);
    cmp(33'(irq), 33'h1);
    $display("mask and irq done");
    cmp(33'(exp_q.size()), 33'h0);
    end_sim;
  end
endmodule
